// >>> rtl/chsel_cfg.svh
// Offsets, field positions, reset values and frame lengths of the channel select register bank
`ifndef CHSEL_CFG_SVH
`define CHSEL_CFG_SVH

// Register select codes
`define CHSEL_RS_STATUS 3'h0
`define CHSEL_RS_MODE 3'h1
`define CHSEL_RS_CONFIG 3'h2
`define CHSEL_RS_DATA 3'h3
`define CHSEL_RS_ID 3'h4

// Command byte layout, first bit on the wire is bit 7
`define CHSEL_CMD_READ_BIT 6
`define CHSEL_CMD_RS_MSB 5
`define CHSEL_CMD_RS_LSB 3
`define CHSEL_CMD_LAST_BIT 6'h07

// Configuration word fields
`define CHSEL_CFG_POS_MSB 15
`define CHSEL_CFG_POS_LSB 12
`define CHSEL_CFG_NEG_MSB 11
`define CHSEL_CFG_NEG_LSB 8
`define CHSEL_CFG_SINGLE_BIT 18

// Mode word fields
`define CHSEL_MODE_APPEND_BIT 20

// Reset values
`define CHSEL_MODE_RESET 24'h000000
`define CHSEL_CONFIG_RESET 24'h000000
`define CHSEL_DATA_RESET 24'h000000

// Frame lengths in serial clocks
`define CHSEL_LEN_BYTE 6'h08
`define CHSEL_LEN_WORD 6'h18
`define CHSEL_LEN_WORD_STATUS 6'h20

`endif

// >>> rtl/chsel_pkg.sv
// Types shared by the channel select register bank
package chsel_pkg;
  typedef enum logic [1:0] {
    CHSEL_ST_CMD = 2'b00,
    CHSEL_ST_READ = 2'b01,
    CHSEL_ST_WRITE = 2'b10
  } chsel_state_t;
endpackage : chsel_pkg

// >>> rtl/chsel_decode.sv
// Channel enable byte to analog input selection decoder
`timescale 1ns/1ns
`include "chsel_cfg.svh"
module chsel_decode (
  input wire logic [23:0] config_word_i,
  output logic [3:0] pos_code_o,
  output logic [3:0] neg_code_o,
  output logic neg_common_o
);
  logic single_ended;

  assign single_ended = config_word_i[`CHSEL_CFG_SINGLE_BIT];
  // Code n routes analog input n+1
  assign pos_code_o = config_word_i[`CHSEL_CFG_POS_MSB:`CHSEL_CFG_POS_LSB];
  // Lower bits are dropped in single-ended mode so they cannot leak into routing
  assign neg_code_o = single_ended ? 4'h0 :
                      config_word_i[`CHSEL_CFG_NEG_MSB:`CHSEL_CFG_NEG_LSB];
  assign neg_common_o = single_ended;
endmodule : chsel_decode

// >>> rtl/chsel_top.sv
// Serial register bank: channel routing, conversion result and identification registers
// Functional notes
// - Differential mode: upper channel code n routes input n+1 as positive input.
// - Differential mode: lower channel code n routes input n+1 as negative input.
// - Status low nibble holds positive-input code of the result's channel.
// - Single-ended mode: positive from upper code, negative is common input.
// - Result register is 24-bit read-only, code 011, resets to zero.
// - Completed result read sets active-low ready high on pin and status bit.
// - With append enabled, status byte follows each 24-bit result in the read.
// - Identification register at code 100 is read-only, fixed value, ignores writes.
`timescale 1ns/1ns
`include "chsel_cfg.svh"
module chsel_top #(
  // Arbitrary identification value
  parameter logic [7:0] ID_VALUE = 8'hA5
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  input wire logic conv_valid_i,
  input wire logic [23:0] conv_data_i,
  output logic dout_o,
  output logic dout_oe_o,
  output logic rdy_n_o,
  output logic [3:0] positive_input_o,
  output logic [3:0] negative_input_o,
  output logic common_input_o
);
  import chsel_pkg::*;

  logic sclk_meta;
  logic sclk_sync;
  logic sclk_prev;
  logic cs_meta;
  logic cs_sync;
  logic din_meta;
  logic din_sync;
  logic sclk_rise;
  logic sclk_fall;

  chsel_state_t state;
  chsel_state_t next_state;
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic [5:0] len;
  logic [5:0] next_len;
  logic [2:0] rs;
  logic [2:0] next_rs;
  logic [31:0] shreg;
  logic [31:0] next_shreg;
  logic [23:0] mode_word;
  logic [23:0] next_mode_word;
  logic [23:0] config_word;
  logic [23:0] next_config_word;
  logic [23:0] result;
  logic [23:0] next_result;
  logic [3:0] result_source_code;
  logic [3:0] next_result_source_code;
  logic rdy_n;
  logic next_rdy_n;
  logic fresh;
  logic next_fresh;
  logic dout;
  logic next_dout;
  logic dout_oe;
  logic next_dout_oe;
  logic [3:0] pos_q;
  logic [3:0] neg_q;
  logic com_q;

  logic [3:0] dec_pos;
  logic [3:0] dec_neg;
  logic dec_com;
  logic [2:0] cmd_rs;
  logic cmd_read;
  logic [7:0] status_byte;
  logic append_status_enable;
  logic [31:0] rd_word;
  logic [5:0] rd_len;
  logic [5:0] wr_len;
  logic [23:0] wr_word;

  chsel_decode u_decode (
    .config_word_i(config_word),
    .pos_code_o(dec_pos),
    .neg_code_o(dec_neg),
    .neg_common_o(dec_com)
  );

  // Pins are asynchronous to clock_i; SCLK must stay slower than a few clock periods per phase
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_meta <= 1'b1;
      sclk_sync <= 1'b1;
      sclk_prev <= 1'b1;
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      din_meta <= 1'b0;
      din_sync <= 1'b0;
    end else begin
      sclk_meta <= sclk_i;
      sclk_sync <= sclk_meta;
      sclk_prev <= sclk_sync;
      cs_meta <= cs_n_i;
      cs_sync <= cs_meta;
      din_meta <= din_i;
      din_sync <= din_meta;
    end
  end

  assign sclk_rise = sclk_sync & ~sclk_prev;
  assign sclk_fall = ~sclk_sync & sclk_prev;

  // Decoded one bit early: at the last command rise the newest bit is not yet in shreg
  assign cmd_rs = shreg[`CHSEL_CMD_RS_MSB - 1:`CHSEL_CMD_RS_LSB - 1];
  assign cmd_read = shreg[`CHSEL_CMD_READ_BIT - 1];
  assign append_status_enable = mode_word[`CHSEL_MODE_APPEND_BIT];
  assign status_byte = {rdy_n, 3'h0, result_source_code};
  assign wr_word = {shreg[22:0], din_sync};

  // Read image left-aligned so the first bit out is always bit 31
  always_comb begin
    rd_word = 32'h00000000;
    rd_len = `CHSEL_LEN_BYTE;
    wr_len = `CHSEL_LEN_BYTE;
    unique case (cmd_rs)
      `CHSEL_RS_STATUS: begin
        rd_word = {status_byte, 24'h000000};
      end
      `CHSEL_RS_MODE: begin
        rd_word = {mode_word, 8'h00};
        rd_len = `CHSEL_LEN_WORD;
        wr_len = `CHSEL_LEN_WORD;
      end
      `CHSEL_RS_CONFIG: begin
        rd_word = {config_word, 8'h00};
        rd_len = `CHSEL_LEN_WORD;
        wr_len = `CHSEL_LEN_WORD;
      end
      `CHSEL_RS_DATA: begin
        if (append_status_enable) begin
          rd_word = {result, status_byte};
          rd_len = `CHSEL_LEN_WORD_STATUS;
        end else begin
          rd_word = {result, 8'h00};
          rd_len = `CHSEL_LEN_WORD;
        end
        wr_len = `CHSEL_LEN_WORD;
      end
      `CHSEL_RS_ID: begin
        rd_word = {ID_VALUE, 24'h000000};
      end
      default: begin
        rd_word = 32'h00000000;
      end
    endcase
  end

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_len = len;
    next_rs = rs;
    next_shreg = shreg;
    next_mode_word = mode_word;
    next_config_word = config_word;
    next_result = result;
    next_result_source_code = result_source_code;
    next_rdy_n = rdy_n;
    next_fresh = fresh;
    next_dout = dout;
    next_dout_oe = ~cs_sync;
    if (cs_sync) begin
      // Deselect aborts any frame; a partial result read does not clear ready
      next_state = CHSEL_ST_CMD;
      next_cnt = 6'h00;
      next_dout = 1'b0;
    end else begin
      unique case (state)
        CHSEL_ST_CMD: begin
          next_dout = rdy_n;
          if (sclk_rise) begin
            next_shreg = {shreg[30:0], din_sync};
            next_cnt = cnt + 6'h01;
            if (cnt == `CHSEL_CMD_LAST_BIT) begin
              next_cnt = 6'h00;
              next_rs = cmd_rs;
              if (cmd_read) begin
                next_state = CHSEL_ST_READ;
                next_shreg = rd_word;
                next_len = rd_len;
                next_fresh = 1'b0;
              end else begin
                next_state = CHSEL_ST_WRITE;
                next_len = wr_len;
              end
            end
          end
        end
        CHSEL_ST_READ: begin
          if (sclk_fall) begin
            next_dout = shreg[31];
            next_shreg = {shreg[30:0], 1'b0};
          end
          if (sclk_rise) begin
            next_cnt = cnt + 6'h01;
            if (cnt == len - 6'h01) begin
              next_state = CHSEL_ST_CMD;
              next_cnt = 6'h00;
              // A result that landed during the read stays pending
              if (rs == `CHSEL_RS_DATA && !fresh) begin
                next_rdy_n = 1'b1;
              end
            end
          end
        end
        CHSEL_ST_WRITE: begin
          if (sclk_rise) begin
            next_shreg = {shreg[30:0], din_sync};
            next_cnt = cnt + 6'h01;
            if (cnt == len - 6'h01) begin
              next_state = CHSEL_ST_CMD;
              next_cnt = 6'h00;
              // Result, status and identification codes fall through unwritten
              if (rs == `CHSEL_RS_MODE) begin
                next_mode_word = wr_word;
              end else if (rs == `CHSEL_RS_CONFIG) begin
                next_config_word = wr_word;
              end
            end
          end
        end
        default: begin
          next_state = CHSEL_ST_CMD;
          next_cnt = 6'h00;
        end
      endcase
    end
    // New result wins over a ready clear in the same cycle
    if (conv_valid_i) begin
      next_result = conv_data_i;
      next_result_source_code = pos_q;
      next_rdy_n = 1'b0;
      next_fresh = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= CHSEL_ST_CMD;
      cnt <= 6'h00;
      len <= `CHSEL_LEN_BYTE;
      rs <= 3'h0;
      shreg <= 32'h00000000;
      mode_word <= `CHSEL_MODE_RESET;
      config_word <= `CHSEL_CONFIG_RESET;
      result <= `CHSEL_DATA_RESET;
      result_source_code <= 4'h0;
      rdy_n <= 1'b1;
      fresh <= 1'b0;
      dout <= 1'b0;
      dout_oe <= 1'b0;
      pos_q <= 4'h0;
      neg_q <= 4'h0;
      com_q <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      len <= next_len;
      rs <= next_rs;
      shreg <= next_shreg;
      mode_word <= next_mode_word;
      config_word <= next_config_word;
      result <= next_result;
      result_source_code <= next_result_source_code;
      rdy_n <= next_rdy_n;
      fresh <= next_fresh;
      dout <= next_dout;
      dout_oe <= next_dout_oe;
      pos_q <= dec_pos;
      neg_q <= dec_neg;
      com_q <= dec_com;
    end
  end

  assign dout_o = dout;
  assign dout_oe_o = dout_oe;
  assign rdy_n_o = rdy_n;
  assign positive_input_o = pos_q;
  assign negative_input_o = neg_q;
  assign common_input_o = com_q;
endmodule : chsel_top

// >>> dv/chsel_top_properties.sv
// Port-level checks of the channel select register bank
`timescale 1ns/1ns
module chsel_top_properties (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic cs_n_i,
  input wire logic conv_valid_i,
  input wire logic dout_o,
  input wire logic dout_oe_o,
  input wire logic rdy_n_o,
  input wire logic [3:0] positive_input_o,
  input wire logic [3:0] negative_input_o,
  input wire logic common_input_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  a_conv_sets_ready: assert property (conv_valid_i |=> !rdy_n_o)
    else $error("ready not low after a result");
  a_ready_fall_cause: assert property ($fell(rdy_n_o) |-> $past(conv_valid_i))
    else $error("ready fell without a result");
  a_set_wins_clear: assert property ($rose(rdy_n_o) |-> !$past(conv_valid_i))
    else $error("ready cleared over a new result");
  // Only a completed read may clear ready, and none completes while deselected
  a_ready_hold_idle: assert property ((!rdy_n_o && cs_n_i && $past(cs_n_i, 4)) |=> !rdy_n_o)
    else $error("ready cleared while deselected");
  a_single_common_neg: assert property (common_input_o |-> negative_input_o == 4'h0)
    else $error("negative code set in single-ended mode");
  a_routing_hold: assert property (cs_n_i [*8] |=> $stable({positive_input_o,
    negative_input_o, common_input_o}))
    else $error("routing moved without a write");
  a_idle_no_drive: assert property (cs_n_i [*6] |-> !dout_oe_o)
    else $error("output driven while deselected");
  a_quiet_dout: assert property (!dout_oe_o |-> !dout_o)
    else $error("output not low while undriven");
  a_select_drives: assert property (!cs_n_i [*5] |-> dout_oe_o)
    else $error("output not driven while selected");
  c_result: cover property (conv_valid_i ##1 !rdy_n_o);
  c_cleared: cover property ($rose(rdy_n_o));
  c_single: cover property ($rose(common_input_o));
endmodule : chsel_top_properties

// >>> dv/chsel_host_model.sv
// Serial host model: frames commands and data on the register port
`timescale 1ns/1ns
module chsel_host_model (
  input wire logic clock_i,
  input wire logic dout_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o
);
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end
  // Phases of five clocks leave margin over the three-flop input path
  task automatic bit_x(input logic b, output logic q);
    @(negedge clock_i);
    sclk_o = 1'b0;
    din_o = b;
    repeat (5) @(negedge clock_i);
    q = dout_i;
    sclk_o = 1'b1;
    repeat (4) @(negedge clock_i);
  endtask : bit_x
  task automatic frame(input logic [7:0] cmd, input int n, input logic [31:0] wd,
                       output logic [31:0] rd);
    logic q;
    rd = 32'h0;
    cs_n_o = 1'b0;
    repeat (6) @(negedge clock_i);
    for (int i = 7; i >= 0; i--) bit_x(cmd[i], q);
    for (int i = n - 1; i >= 0; i--) begin
      // Unused input toggles during reads rather than hold a stale level
      bit_x(cmd[6] ? ~din_o : wd[i], q);
      rd = {rd[30:0], q};
    end
    repeat (10) @(negedge clock_i);
    cs_n_o = 1'b1;
    din_o = ~din_o;
    repeat (10) @(negedge clock_i);
  endtask : frame
endmodule : chsel_host_model

// >>> dv/chsel_top_test.sv
// Self-checking bench for the channel select register bank
`timescale 1ns/1ns
module chsel_top_test;
  // Arbitrary identification value
  localparam logic [7:0] ID_VAL = 8'h3C;
  typedef struct {logic [23:0] cfg; logic [3:0] pos; logic [3:0] neg; logic com;} chsel_row_t;
  chsel_row_t rows [6] = '{'{24'h000000, 4'h0, 4'h0, 1'b0}, '{24'h00F000, 4'hF, 4'h0, 1'b0},
    '{24'h000F00, 4'h0, 4'hF, 1'b0}, '{24'h00A500, 4'hA, 4'h5, 1'b0},
    '{24'h043C00, 4'h3, 4'h0, 1'b1}, '{24'h04FF00, 4'hF, 4'h0, 1'b1}};
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic conv_valid_i = 1'b0;
  logic [23:0] conv_data_i = 24'h000000;
  logic sclk, cs_n, din, dout_o, dout_oe_o, rdy_n_o, common_input_o;
  logic [3:0] positive_input_o, negative_input_o;
  logic [31:0] rd;
  logic [23:0] res;
  int err_total = 0;
  int samples_checked = 0;
  always #5 clock_i = ~clock_i;
  chsel_host_model u_chsel_host_model (.clock_i(clock_i), .dout_i(dout_o), .sclk_o(sclk),
    .cs_n_o(cs_n), .din_o(din));
  chsel_top #(.ID_VALUE(ID_VAL)) u_chsel_top (.clock_i(clock_i), .resetn_i(resetn_i),
    .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din), .conv_valid_i(conv_valid_i),
    .conv_data_i(conv_data_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o), .rdy_n_o(rdy_n_o),
    .positive_input_o(positive_input_o), .negative_input_o(negative_input_o),
    .common_input_o(common_input_o));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic conv(input logic [23:0] d);
    @(negedge clock_i);
    conv_valid_i = 1'b1;
    conv_data_i = d;
    @(negedge clock_i);
    conv_valid_i = 1'b0;
  endtask : conv
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  initial begin
    repeat (10) @(negedge clock_i);
    resetn_i = 1'b1;
    repeat (5) @(negedge clock_i);
    // Several channels follow, so results carry their status byte
    u_chsel_host_model.frame(8'h08, 24, 32'h100000, rd);
    foreach (rows[k]) begin
      res = rows[k].cfg ^ 24'h5A5A5A;
      u_chsel_host_model.frame(8'h10, 24, {8'h00, rows[k].cfg}, rd);
      chk("positive", {28'h0, rows[k].pos}, {28'h0, positive_input_o});
      chk("negative", {28'h0, rows[k].neg}, {28'h0, negative_input_o});
      chk("common", {31'h0, rows[k].com}, {31'h0, common_input_o});
      conv(res);
      u_chsel_host_model.frame(8'h40, 8, 32'h0, rd);
      chk("status source", {28'h0, rows[k].pos}, rd);
      u_chsel_host_model.frame(8'h58, 32, 32'h0, rd);
      chk("result and status", {res, 4'h0, rows[k].pos}, rd);
      chk("ready after read", 32'h1, {31'h0, rdy_n_o});
    end
    $display("routing table done");
    resetn_i = 1'b0;
    repeat (10) @(negedge clock_i);
    chk("ready in reset", 32'h1, {31'h0, rdy_n_o});
    chk("routing in reset", 32'h0,
      {23'h0, positive_input_o, negative_input_o, common_input_o});
    resetn_i = 1'b1;
    repeat (5) @(negedge clock_i);
    u_chsel_host_model.frame(8'h18, 24, 32'hFFFFFF, rd);
    u_chsel_host_model.frame(8'h58, 24, 32'h0, rd);
    chk("result after reset and write", 32'h0, rd);
    u_chsel_host_model.frame(8'h20, 8, 32'h5A, rd);
    u_chsel_host_model.frame(8'h60, 8, 32'h0, rd);
    chk("identification", {24'h0, ID_VAL}, rd);
    conv(24'h123456);
    u_chsel_host_model.frame(8'h58, 8, 32'h0, rd);
    chk("partial result", 32'h12, rd);
    chk("ready after abort", 32'h0, {31'h0, rdy_n_o});
    u_chsel_host_model.frame(8'h58, 24, 32'h0, rd);
    chk("full result", 32'h123456, rd);
    chk("ready after full read", 32'h1, {31'h0, rdy_n_o});
    // A result landing mid-read must leave ready low after that read completes
    fork
      u_chsel_host_model.frame(8'h58, 24, 32'h0, rd);
      begin
        repeat (150) @(negedge clock_i);
        conv(24'hABCDEF);
      end
    join
    chk("result image at command", 32'h123456, rd);
    chk("ready kept by new result", 32'h0, {31'h0, rdy_n_o});
    u_chsel_host_model.frame(8'h58, 24, 32'h0, rd);
    chk("newer result", 32'hABCDEF, rd);
    chk("ready after newer read", 32'h1, {31'h0, rdy_n_o});
    $display("reset, write and abort cases done");
    complete_run();
  end
endmodule : chsel_top_test
bind chsel_top chsel_top_properties u_chsel_top_properties (.clock_i(clock_i),
  .resetn_i(resetn_i), .cs_n_i(cs_n_i), .conv_valid_i(conv_valid_i), .dout_o(dout_o),
  .dout_oe_o(dout_oe_o), .rdy_n_o(rdy_n_o), .positive_input_o(positive_input_o),
  .negative_input_o(negative_input_o), .common_input_o(common_input_o));
